// File: design/irq_status_pkg.sv
// Constants shared by the Ethernet interrupt status bank
package irq_status_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_IRQ_CONFIG = 8'h54;
  localparam logic [7:0] OFS_STATUS = 8'h58;
  localparam logic [7:0] OFS_ENABLE = 8'h5C;
  localparam logic [7:0] OFS_BYTE_TEST = 8'h64;
  localparam logic [7:0] OFS_FIFO_LEVEL = 8'h68;
  localparam logic [7:0] OFS_RX_CONFIG = 8'h6C;
  localparam logic [7:0] OFS_GP_PIN_CONFIG = 8'h88;
  // Status bit positions
  localparam int BIT_SW = 31;
  localparam int BIT_TX_HALT = 25;
  localparam int BIT_RX_HALT = 24;
  localparam int BIT_DROP_MID = 23;
  localparam int BIT_TX_DONE = 21;
  localparam int BIT_RX_DMA = 20;
  localparam int BIT_TIMER = 19;
  localparam int BIT_PHY = 18;
  localparam int BIT_POWER = 17;
  localparam int BIT_TXS_OVF = 16;
  localparam int BIT_RX_WDOG = 15;
  localparam int BIT_RX_ERR = 14;
  localparam int BIT_TX_ERR = 13;
  localparam int BIT_TXD_OVR = 10;
  localparam int BIT_TX_SPACE = 9;
  localparam int BIT_TXS_FULL = 8;
  localparam int BIT_TXS_LEVEL = 7;
  localparam int BIT_DROPPED = 6;
  localparam int BIT_RXS_FULL = 4;
  localparam int BIT_RXS_LEVEL = 3;
  // Write-one-to-clear bits, and all defined bits (adds the PHY bit)
  localparam logic [31:0] STATUS_W1C_MASK = 32'h83BB_E7DF;
  localparam logic [31:0] STATUS_DEF_MASK = 32'h83BF_E7DF;
  // Config register fields
  localparam int CFG_OUT_EN_BIT = 8;
  localparam int CFG_MASTER_BIT = 12;
  localparam int DMA_CNT_LSB = 16;
  localparam int GP_POL_LSB = 8;
  // Reset values and fixed patterns
  localparam logic [7:0] TX_SPACE_LEVEL_RESET = 8'h48;
  localparam logic [31:0] BYTE_TEST_VALUE = 32'h8765_4321;
  localparam logic [31:0] DROP_MID_BEFORE = 32'h7FFF_FFFF;
  localparam logic [31:0] DROP_MID_AFTER = 32'h8000_0000;
  localparam logic [15:0] TIMER_WRAP_VALUE = 16'hFFFF;
  localparam logic [15:0] WATCHDOG_BYTES = 16'h0800;
endpackage

// File: design/ethernet_interrupt_status_bank.sv
// Ethernet interrupt status bank with Avalon-MM register slave
// Notes on behaviour
// - Writing one clears status bit; zero keeps
// - Bit 31 sets when software enable rises
// - Bit 25 sets when stopped transmitter halts
// - Bit 24 sets when receiver halts
// - Bit 23 sets at drop counter midpoint
// - Bit 21 sets on notify buffer loaded
// - Bit 20 sets when DMA count exhausted
// - Bit 19 sets on timer wrap to FFFF
// - Bit 18 mirrors transceiver source, read-only
// - Bit 17 sets on power event always
// - Only byte test write ends low power
// - Power status never delayed by hold-off
// - Bit 16 sets on status FIFO overflow
// - Bit 15 sets on frame over 2048
// - Bit 14 sets on receive error
// - Bit 13 sets on transmit error
// - Bit 10 sets on write to full FIFO
// - Bit 9 sets when space exceeds threshold
// - Bits 8 and 4 set on full
// - Bits 7 and 3 set on level
// - Bit 6 sets on dropped frame
// - Bits 2-0 latch selected pin events
// - Status records events regardless of mask
// - Master indication is any enabled status
`timescale 1ns/1ns
`default_nettype none
module ethernet_interrupt_status_bank
  import irq_status_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic stop_tx_i,
  input wire logic tx_halted_i,
  input wire logic rx_halted_i,
  input wire logic [31:0] drop_counter_i,
  input wire logic tx_buffer_loaded_i,
  input wire logic completion_notify_flag_i,
  input wire logic rx_word_read_i,
  input wire logic [15:0] timer_value_i,
  input wire logic line_transceiver_irq_i,
  input wire logic power_event_i,
  input wire logic enter_low_power_i,
  input wire logic tx_status_overflow_i,
  input wire logic rx_frame_done_i,
  input wire logic [15:0] rx_frame_bytes_i,
  input wire logic rx_error_i,
  input wire logic tx_error_i,
  input wire logic tx_data_write_i,
  input wire logic tx_data_full_i,
  input wire logic [7:0] tx_free_blocks_i,
  input wire logic tx_status_full_i,
  input wire logic rx_status_full_i,
  input wire logic [7:0] tx_status_used_i,
  input wire logic [7:0] rx_status_used_i,
  input wire logic frame_dropped_i,
  input wire logic [2:0] general_pins_i,
  output logic master_irq_o,
  output logic irq_o,
  output logic low_power_o
);

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] enable;
    logic out_en;
    logic [7:0] tx_space_level;
    logic [7:0] tx_status_level;
    logic [7:0] rx_status_level;
    logic [11:0] dma_count;
    logic [2:0] gp_enable;
    logic [2:0] gp_rising;
    logic sleeping;
    logic ack;
    logic [31:0] rdata;
    logic halt_q;
    logic rx_halt_q;
    logic [31:0] drop_q;
    logic [15:0] timer_q;
    logic space_q;
    logic txs_full_q;
    logic rxs_full_q;
    logic txs_lvl_q;
    logic rxs_lvl_q;
    logic [2:0] gp_s1;
    logic [2:0] gp_s2;
    logic [2:0] gp_s3;
    logic [2:0] gp_level;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic req;
  logic take;
  logic [31:0] status_view;
  logic [31:0] bmask;
  logic [31:0] events;
  logic [31:0] clear;
  logic [31:0] rd_mux;
  logic tx_space_now;
  logic txs_lvl_now;
  logic rxs_lvl_now;
  logic [2:0] gp_agree;
  logic [2:0] gp_change;

  // Transaction takes effect on the cycle waitrequest is low
  assign req = read_i | write_i;
  assign take = req & cur.ack;
  assign waitrequest_o = req & ~cur.ack;
  assign bmask = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                  {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  // Transceiver bit is a live view of its source, not stored
  assign status_view = (cur.status & STATUS_W1C_MASK)
                     | ({31'h0, line_transceiver_irq_i} << BIT_PHY);

  // Threshold comparisons for level sources
  assign tx_space_now = tx_free_blocks_i > cur.tx_space_level;
  assign txs_lvl_now = tx_status_used_i > cur.tx_status_level;
  assign rxs_lvl_now = rx_status_used_i > cur.rx_status_level;

  // Pin level changes once the two later sync stages agree
  assign gp_agree = ~(cur.gp_s2 ^ cur.gp_s3);
  assign gp_change = gp_agree & (cur.gp_s3 ^ cur.gp_level);

  // Source events as single-cycle pulses; levels are edge-detected
  always_comb begin
    events = 32'h0;
    events[BIT_SW] = take & write_i & (address_i == OFS_ENABLE)
      & byteenable_i[3] & writedata_i[BIT_SW] & ~cur.enable[BIT_SW];
    events[BIT_TX_HALT] = (stop_tx_i & tx_halted_i) & ~cur.halt_q;
    events[BIT_RX_HALT] = rx_halted_i & ~cur.rx_halt_q;
    events[BIT_DROP_MID] = (cur.drop_q == DROP_MID_BEFORE)
      & (drop_counter_i == DROP_MID_AFTER);
    events[BIT_TX_DONE] = tx_buffer_loaded_i
      & completion_notify_flag_i;
    events[BIT_RX_DMA] = rx_word_read_i
      & (cur.dma_count == 12'h001);
    events[BIT_TIMER] = (cur.timer_q == 16'h0000)
      & (timer_value_i == TIMER_WRAP_VALUE);
    events[BIT_POWER] = power_event_i;
    events[BIT_TXS_OVF] = tx_status_overflow_i;
    events[BIT_RX_WDOG] = rx_frame_done_i
      & (rx_frame_bytes_i > WATCHDOG_BYTES);
    events[BIT_RX_ERR] = rx_error_i;
    events[BIT_TX_ERR] = tx_error_i;
    events[BIT_TXD_OVR] = tx_data_write_i & tx_data_full_i;
    events[BIT_TX_SPACE] = tx_space_now & ~cur.space_q;
    events[BIT_TXS_FULL] = tx_status_full_i & ~cur.txs_full_q;
    events[BIT_RXS_FULL] = rx_status_full_i & ~cur.rxs_full_q;
    events[BIT_TXS_LEVEL] = txs_lvl_now & ~cur.txs_lvl_q;
    events[BIT_RXS_LEVEL] = rxs_lvl_now & ~cur.rxs_lvl_q;
    events[BIT_DROPPED] = frame_dropped_i;
    events[2:0] = gp_change & cur.gp_enable
      & ~(cur.gp_s3 ^ cur.gp_rising);
  end

  // Write-one-to-clear request for status
  assign clear = (take & write_i & (address_i == OFS_STATUS))
               ? (writedata_i & bmask & STATUS_W1C_MASK) : 32'h0;

  // Read data multiplexer, unmapped offsets read zero
  always_comb begin
    case (address_i)
      OFS_IRQ_CONFIG: rd_mux = {19'h0, master_irq_o, 3'h0, cur.out_en, 8'h0};
      OFS_STATUS: rd_mux = status_view;
      OFS_ENABLE: rd_mux = cur.enable;
      OFS_BYTE_TEST: rd_mux = BYTE_TEST_VALUE;
      OFS_FIFO_LEVEL: rd_mux = {cur.tx_space_level, cur.tx_status_level,
                                8'h0, cur.rx_status_level};
      OFS_RX_CONFIG: rd_mux = {4'h0, cur.dma_count, 16'h0};
      OFS_GP_PIN_CONFIG: rd_mux = {21'h0, cur.gp_rising, 5'h0, cur.gp_enable};
      default: rd_mux = 32'h0;
    endcase
  end

  // Next-state logic for every register of the block
  always_comb begin
    next_cur = cur;
    next_cur.ack = req & ~cur.ack;
    if (read_i & ~cur.ack) begin
      next_cur.rdata = rd_mux;
    end
    // Set has priority over the same-cycle clear
    next_cur.status = ((cur.status & ~clear) | events)
                    & STATUS_W1C_MASK;
    next_cur.halt_q = stop_tx_i & tx_halted_i;
    next_cur.rx_halt_q = rx_halted_i;
    next_cur.drop_q = drop_counter_i;
    next_cur.timer_q = timer_value_i;
    next_cur.space_q = tx_space_now;
    next_cur.txs_full_q = tx_status_full_i;
    next_cur.rxs_full_q = rx_status_full_i;
    next_cur.txs_lvl_q = txs_lvl_now;
    next_cur.rxs_lvl_q = rxs_lvl_now;
    next_cur.gp_s1 = general_pins_i;
    next_cur.gp_s2 = cur.gp_s1;
    next_cur.gp_s3 = cur.gp_s2;
    next_cur.gp_level = cur.gp_level ^ gp_change;
    // DMA counter counts words down; a write overrides it
    if (rx_word_read_i && cur.dma_count != 12'h000) begin
      next_cur.dma_count = cur.dma_count - 12'h001;
    end
    // Sleep request comes from the power block; only a byte test write wakes
    if (enter_low_power_i) begin
      next_cur.sleeping = 1'b1;
    end
    if (take & write_i) begin
      case (address_i)
        OFS_IRQ_CONFIG: begin
          if (byteenable_i[1]) begin
            next_cur.out_en = writedata_i[CFG_OUT_EN_BIT];
          end
        end
        OFS_ENABLE: begin
          next_cur.enable = (cur.enable & ~bmask)
                          | (writedata_i & bmask & STATUS_DEF_MASK);
        end
        OFS_BYTE_TEST: begin
          next_cur.sleeping = 1'b0;
        end
        OFS_FIFO_LEVEL: begin
          if (byteenable_i[3]) next_cur.tx_space_level = writedata_i[31:24];
          if (byteenable_i[2]) next_cur.tx_status_level = writedata_i[23:16];
          if (byteenable_i[0]) next_cur.rx_status_level = writedata_i[7:0];
        end
        OFS_RX_CONFIG: begin
          if (byteenable_i[3] & byteenable_i[2]) begin
            next_cur.dma_count = writedata_i[DMA_CNT_LSB +: 12];
          end
        end
        OFS_GP_PIN_CONFIG: begin
          if (byteenable_i[0]) next_cur.gp_enable = writedata_i[2:0];
          if (byteenable_i[1]) begin
            next_cur.gp_rising = writedata_i[GP_POL_LSB +: 3];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
      cur.tx_space_level <= TX_SPACE_LEVEL_RESET;
    end else if (ce_i) begin
      cur <= next_cur;
    end
  end

  // Master indication ignores output enable; no hold-off exists, so the
  // power bit reaches the output undelayed
  assign master_irq_o = |(status_view & cur.enable);
  assign irq_o = master_irq_o & cur.out_en;
  assign readdata_o = cur.rdata;
  assign low_power_o = cur.sleeping;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_clear_one;
    ce_i && take && write_i && address_i == OFS_STATUS && bmask[BIT_RX_ERR]
      && writedata_i[BIT_RX_ERR] && !events[BIT_RX_ERR]
      |=> !status_view[BIT_RX_ERR];
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("status bit not cleared by one");

  property p_write_zero_keeps;
    ce_i && take && write_i && address_i == OFS_STATUS
      && status_view[BIT_TX_ERR] && !writedata_i[BIT_TX_ERR]
      |=> status_view[BIT_TX_ERR];
  endproperty
  a_write_zero_keeps: assert property (p_write_zero_keeps)
    else $error("zero write changed status bit");

  property p_set_wins;
    ce_i && events[BIT_DROPPED] && clear[BIT_DROPPED]
      |=> status_view[BIT_DROPPED];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a coinciding set");

  property p_drop_mid;
    ce_i && drop_counter_i == DROP_MID_AFTER
      && $past(drop_counter_i) == DROP_MID_BEFORE && $past(ce_i)
      |=> status_view[BIT_DROP_MID];
  endproperty
  a_drop_mid: assert property (p_drop_mid)
    else $error("midpoint crossing not flagged");

  property p_timer_wrap;
    ce_i && $past(ce_i) && $past(timer_value_i) == 16'h0000
      && timer_value_i == TIMER_WRAP_VALUE
      |=> status_view[BIT_TIMER];
  endproperty
  a_timer_wrap: assert property (p_timer_wrap)
    else $error("timer wrap not flagged");

  property p_phy_mirror;
    status_view[BIT_PHY] == line_transceiver_irq_i;
  endproperty
  a_phy_mirror: assert property (p_phy_mirror)
    else $error("transceiver bit not a mirror");

  property p_power_sticky;
    ce_i && power_event_i |=> status_view[BIT_POWER]
      ##1 (status_view[BIT_POWER] || $past(clear[BIT_POWER]) || !$past(ce_i));
  endproperty
  a_power_sticky: assert property (p_power_sticky)
    else $error("power bit lost without clear");

  property p_wake_only_by_write;
    low_power_o && !(take && write_i && address_i == OFS_BYTE_TEST)
      |=> low_power_o;
  endproperty
  a_wake_only_by_write: assert property (p_wake_only_by_write)
    else $error("woke without byte test write");

  property p_watchdog;
    ce_i && rx_frame_done_i && rx_frame_bytes_i == 16'h0801
      |=> status_view[BIT_RX_WDOG];
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("long frame not flagged");

  property p_master;
    master_irq_o == |(status_view & cur.enable) && (irq_o -> master_irq_o);
  endproperty
  a_master: assert property (p_master)
    else $error("master indication mismatch");

  property p_reserved_zero;
    take && read_i && address_i == OFS_STATUS
      |=> (readdata_o & ~STATUS_DEF_MASK) == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved status bits read nonzero");

  property p_wait_one;
    req && !cur.ack && ce_i |=> !waitrequest_o || !req;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest held too long");

  c_clear: cover property (take && write_i && address_i == OFS_STATUS);
  c_irq: cover property (irq_o);
  c_wake: cover property (low_power_o ##1 !low_power_o);
  c_gp: cover property (status_view[0]);

endmodule // ethernet_interrupt_status_bank
`default_nettype wire

// File: testbench/host_bus_model.sv
// Host processor model issuing Avalon-MM register cycles
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input wire logic clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o
);
  // Bus idles with no request and all byte lanes selected
  initial begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
    byteenable_o = 4'hF;
  end

  // Hold the request until waitrequest is seen low at a rising edge; read
  // data is taken at that same edge, before the slave's state moves on
  task automatic finish_cycle(output logic [31:0] data);
    logic busy;
    busy = 1'b1;
    data = 32'h0000_0000;
    while (busy) begin
      @(posedge clk_i);
      busy = waitrequest_i;
      data = readdata_i;
    end
    read_o <= 1'b0;
    write_o <= 1'b0;
    @(posedge clk_i); // Gap so the next request is a fresh assignment
  endtask

  // Status acknowledge and wake-up are plain writes from the host
  task automatic bus_write(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    address_o <= addr;
    writedata_o <= data;
    write_o <= 1'b1;
    finish_cycle(unused);
  endtask

  task automatic bus_read(input logic [7:0] addr, output logic [31:0] data);
    address_o <= addr;
    read_o <= 1'b1;
    finish_cycle(data);
  endtask
endmodule // host_bus_model
`default_nettype wire

// File: testbench/tb_ethernet_interrupt_status_bank.sv
// Self-checking bench for the Ethernet interrupt status bank
`timescale 1ns/1ns
`default_nettype none
module tb_ethernet_interrupt_status_bank
  import irq_status_pkg::*;
;
  logic ref_clk_i, rst_n_i, ce_i, read_i, write_i, waitrequest_o;
  logic [7:0] address_i, tx_free_blocks_i, tx_status_used_i, rx_status_used_i;
  logic [31:0] writedata_i, readdata_o, drop_counter_i;
  logic [3:0] byteenable_i;
  logic stop_tx_i, tx_halted_i, tx_buffer_loaded_i, completion_notify_flag_i;
  logic rx_word_read_i, line_transceiver_irq_i, enter_low_power_i;
  logic rx_frame_done_i, tx_data_write_i, tx_data_full_i;
  logic master_irq_o, irq_o, low_power_o;
  logic [15:0] timer_value_i, rx_frame_bytes_i;
  logic [2:0] general_pins_i, lv;
  logic [4:0] pl;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  ethernet_interrupt_status_bank u_dut (.ref_clk_i, .rst_n_i, .ce_i,
    .address_i, .read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o,
    .waitrequest_o, .stop_tx_i, .tx_halted_i, .rx_halted_i(lv[0]),
    .drop_counter_i, .tx_buffer_loaded_i, .completion_notify_flag_i,
    .rx_word_read_i, .timer_value_i, .line_transceiver_irq_i,
    .power_event_i(pl[4]), .enter_low_power_i, .tx_status_overflow_i(pl[0]),
    .rx_frame_done_i, .rx_frame_bytes_i, .rx_error_i(pl[1]),
    .tx_error_i(pl[2]), .tx_data_write_i, .tx_data_full_i, .tx_free_blocks_i,
    .tx_status_full_i(lv[1]), .rx_status_full_i(lv[2]), .tx_status_used_i,
    .rx_status_used_i, .frame_dropped_i(pl[3]), .general_pins_i,
    .master_irq_o, .irq_o, .low_power_o);

  host_bus_model host (.clk_i(ref_clk_i), .waitrequest_i(waitrequest_o),
    .readdata_i(readdata_o), .address_o(address_i), .read_o(read_i),
    .write_o(write_i), .writedata_o(writedata_i),
    .byteenable_o(byteenable_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // A hung handshake must still end the run with a verdict
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    host.bus_read(a, d);
    chk(n, e, d);
  endtask

  // One flag set: zero writes keep it, a one clears it even if source stays
  task automatic sts(input int b);
    rd(OFS_STATUS, 32'h1 << b, "flag set");
    host.bus_write(OFS_STATUS, ~(32'h1 << b));
    rd(OFS_STATUS, 32'h1 << b, "flag kept");
    host.bus_write(OFS_STATUS, 32'h1 << b);
    rd(OFS_STATUS, 32'h0, "flag cleared");
  endtask

  task automatic t_regs();
    rd(OFS_STATUS, 32'h0, "status reset");
    rd(OFS_FIFO_LEVEL, 32'h4800_0000, "level reset");
    rd(OFS_BYTE_TEST, 32'h8765_4321, "byte test");
    host.bus_write(8'h60, 32'hFFFF_FFFF);
    rd(8'h60, 32'h0, "unmapped");
    host.bus_write(OFS_ENABLE, 32'hFFFF_FFFF);
    rd(OFS_ENABLE, 32'h83BF_E7DF, "enable");
    rd(OFS_STATUS, 32'h8000_0000, "sw flag");
    chk("master", 32'h1, {31'h0, master_irq_o});
    chk("irq off", 32'h0, {31'h0, irq_o});
    host.bus_write(OFS_IRQ_CONFIG, 32'h0000_0100);
    rd(OFS_IRQ_CONFIG, 32'h0000_1100, "config");
    chk("irq on", 32'h1, {31'h0, irq_o});
    host.bus_write(OFS_STATUS, 32'h8000_0000);
    rd(OFS_STATUS, 32'h0, "sw cleared");
    chk("master off", 32'h0, {31'h0, master_irq_o});
    host.bus_write(OFS_ENABLE, 32'h0);
    host.bus_write(OFS_IRQ_CONFIG, 32'h0);
    $display("test registers done");
  endtask

  // Mask stays clear here, so every flag must still record its event
  task automatic t_events();
    int pb[5] = '{16, 14, 13, 6, 17};
    int lb[3] = '{24, 8, 4};
    for (int i = 0; i < 5; i++) begin
      pl <= 5'h01 << i;
      cyc(1);
      pl <= 5'h00;
      cyc(1);
      sts(pb[i]);
    end
    for (int i = 0; i < 3; i++) begin
      lv <= 3'h1 << i;
      cyc(2);
      sts(lb[i]);
      lv <= 3'h0;
      cyc(1);
    end
    tx_halted_i <= 1'b1;
    cyc(2);
    rd(OFS_STATUS, 32'h0, "halt alone");
    stop_tx_i <= 1'b1;
    cyc(2);
    sts(25);
    {stop_tx_i, tx_halted_i} <= 2'h0;
    drop_counter_i <= 32'h7FFF_FFFF;
    cyc(2);
    rd(OFS_STATUS, 32'h0, "below midpoint");
    drop_counter_i <= 32'h8000_0000;
    cyc(2);
    sts(23);
    timer_value_i <= 16'h0000;
    cyc(1);
    timer_value_i <= 16'hFFFF;
    cyc(2);
    sts(19);
    line_transceiver_irq_i <= 1'b1;
    cyc(2);
    host.bus_write(OFS_STATUS, 32'h0004_0000);
    rd(OFS_STATUS, 32'h0004_0000, "phy held");
    line_transceiver_irq_i <= 1'b0;
    cyc(2);
    rd(OFS_STATUS, 32'h0, "phy gone");
    $display("test events done");
  endtask

  task automatic t_power();
    host.bus_write(OFS_ENABLE, 32'h0002_0000);
    enter_low_power_i <= 1'b1;
    cyc(1);
    enter_low_power_i <= 1'b0;
    pl <= 5'h10;
    cyc(1);
    pl <= 5'h00;
    cyc(1);
    chk("power master", 32'h1, {31'h0, master_irq_o});
    chk("asleep", 32'h1, {31'h0, low_power_o});
    host.bus_write(OFS_BYTE_TEST, 32'h0000_0000);
    chk("awake", 32'h0, {31'h0, low_power_o});
    host.bus_write(OFS_ENABLE, 32'h0);
    sts(17);
    // With the clock enable low a dropped frame must leave no trace
    ce_i <= 1'b0;
    pl <= 5'h08;
    cyc(2);
    {ce_i, pl} <= 6'h20;
    cyc(1);
    rd(OFS_STATUS, 32'h0, "frozen drop");
    $display("test power done");
  endtask

  // Thresholds are probed at the exact level and one above it
  task automatic t_fifo();
    tx_data_full_i <= 1'b1;
    tx_free_blocks_i <= 8'h48;
    cyc(2);
    rd(OFS_STATUS, 32'h0, "full or level only");
    tx_data_write_i <= 1'b1;
    cyc(1);
    {tx_data_write_i, tx_data_full_i} <= 2'h0;
    cyc(1);
    sts(10);
    tx_free_blocks_i <= 8'h49;
    cyc(2);
    sts(9);
    host.bus_write(OFS_FIFO_LEVEL, 32'h4805_0003);
    tx_status_used_i <= 8'h05;
    rx_status_used_i <= 8'h03;
    cyc(2);
    rd(OFS_STATUS, 32'h0, "at level");
    tx_status_used_i <= 8'h06;
    cyc(2);
    sts(7);
    rx_status_used_i <= 8'h04;
    cyc(2);
    sts(3);
    for (int i = 0; i < 2; i++) begin
      rx_frame_bytes_i <= 16'h0800 + 16'(i);
      rx_frame_done_i <= 1'b1;
      cyc(1);
      rx_frame_done_i <= 1'b0;
      cyc(1);
      if (i == 0) rd(OFS_STATUS, 32'h0, "frame 2048");
    end
    sts(15);
    for (int i = 0; i < 2; i++) begin
      completion_notify_flag_i <= 1'(i);
      tx_buffer_loaded_i <= 1'b1;
      cyc(1);
      tx_buffer_loaded_i <= 1'b0;
      cyc(1);
      if (i == 0) rd(OFS_STATUS, 32'h0, "no notify");
    end
    sts(21);
    host.bus_write(OFS_RX_CONFIG, 32'h0002_0000);
    for (int i = 0; i < 2; i++) begin
      rx_word_read_i <= 1'b1;
      cyc(1);
      rx_word_read_i <= 1'b0;
      cyc(1);
      if (i == 0) rd(OFS_STATUS, 32'h0, "one word left");
    end
    sts(20);
    $display("test fifo done");
  endtask

  // Pins pass a synchroniser, so each change is given several cycles
  task automatic t_pins();
    host.bus_write(OFS_GP_PIN_CONFIG, 32'h0000_0101);
    general_pins_i <= 3'b001;
    cyc(6);
    sts(0);
    host.bus_write(OFS_GP_PIN_CONFIG, 32'h0000_0002);
    general_pins_i <= 3'b011;
    cyc(6);
    rd(OFS_STATUS, 32'h0, "pin rise ignored");
    general_pins_i <= 3'b001;
    cyc(6);
    sts(1);
    $display("test pins done");
  endtask

  initial begin
    {stop_tx_i, tx_halted_i, tx_buffer_loaded_i, completion_notify_flag_i,
      rx_word_read_i, line_transceiver_irq_i, enter_low_power_i,
      rx_frame_done_i, tx_data_write_i, tx_data_full_i} = '0;
    {drop_counter_i, rx_frame_bytes_i, tx_free_blocks_i} = '0;
    {tx_status_used_i, rx_status_used_i, general_pins_i, lv, pl} = '0;
    timer_value_i = 16'h0005;
    ce_i = 1'b1;
    rst_n_i = 1'b0;
    cyc(3);
    rst_n_i <= 1'b1;
    cyc(1);
    t_regs();
    t_events();
    t_power();
    t_fifo();
    t_pins();
    stop_test();
  end
endmodule // tb_ethernet_interrupt_status_bank
`default_nettype wire
